// [src/adc_ctrl_pkg.sv]
/*
  constants, register map and carrier types of the converter control block.
  assumes an 8-bit apb byte address and 32-bit data.
*/
package adc_ctrl_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_CONFIG = 8'h04;
  localparam logic [7:0] OFF_CMP_CTRL = 8'h08;
  localparam logic [7:0] OFF_CMP_VALUE = 8'h0c;
  localparam logic [7:0] OFF_RESULT = 8'h10;
  localparam logic [7:0] OFF_PIN_LOW = 8'h14;
  localparam logic [7:0] OFF_PIN_MID = 8'h18;
  localparam logic [7:0] OFF_PIN_HIGH = 8'h1c;

  // control register fields
  localparam int CTL_CHAN_LSB = 0;
  localparam int CTL_IRQ_EN_BIT = 6;
  localparam int CTL_DONE_BIT = 7;
  // configuration register fields
  localparam int CFG_CLK_LSB = 0;
  localparam int CFG_MODE_LSB = 2;
  localparam int CFG_DIV_LSB = 5;
  // compare control fields
  localparam int CMP_GT_BIT = 4;
  localparam int CMP_EN_BIT = 5;

  // reset values
  localparam logic [4:0] CHAN_OFF = 5'h1f;
  localparam logic [7:0] PINS_RESET = 8'h00;
  localparam logic [11:0] WORD12_ZERO = 12'h000;

  // input clock sources
  localparam logic [1:0] CLK_BUS = 2'h0;
  localparam logic [1:0] CLK_BUS_HALF = 2'h1;
  localparam logic [1:0] CLK_ALT = 2'h2;
  localparam logic [1:0] CLK_ASYNC = 2'h3;

  // conversion modes
  localparam logic [1:0] MODE_8 = 2'h0;
  localparam logic [1:0] MODE_12 = 2'h1;
  localparam logic [1:0] MODE_10 = 2'h2;

  // successive approximation figures
  localparam logic [3:0] SAR_MSB = 4'hb;
  localparam logic [3:0] SAR_LSB_12 = 4'h0;
  localparam logic [3:0] SAR_LSB_9 = 4'h3;
  localparam logic [11:0] SAR_FIRST = 12'h800;
  localparam logic [4:0] SAMPLE_TICKS = 5'h04;
  localparam logic [11:0] MAX_10 = 12'h3ff;
  localparam logic [11:0] MAX_8 = 12'h0ff;

  // conversion sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SAMPLE = 4'b0010,
    ST_CONVERT = 4'b0100,
    ST_STORE = 4'b1000
  } conv_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  // port logic side of the 24 shared pins
  typedef struct packed {
    logic [23:0] out_en;
    logic [23:0] pullup_en;
    logic [23:0] pad_in;
  } port_req_t;

  // what the pads and the port read path see
  typedef struct packed {
    logic [23:0] out_en;
    logic [23:0] pullup_en;
    logic [23:0] in_buf_en;
    logic [23:0] read_data;
  } port_rsp_t;

endpackage : adc_ctrl_pkg

// [src/adc_pin_gate.sv]
/*
  gating of eight shared pins between port logic and analog use.
  assumes the port logic signals are synchronous to ref_clk_i.
*/
`timescale 1ns/10ps
module adc_pin_gate
  import adc_ctrl_pkg::*;
(
  input wire logic ref_clk_i, // bus clock
  input wire logic rstn_i, // async reset, active low
  input wire logic [7:0] analog_sel_i, // 1 = pin given to analog use
  input wire logic [7:0] out_en_i, // port output enables
  input wire logic [7:0] pullup_en_i, // port pullup requests
  input wire logic [7:0] pad_in_i, // pad input levels
  output logic [7:0] out_en_o, // gated output enables
  output logic [7:0] pullup_en_o, // gated pullups
  output logic [7:0] in_buf_en_o, // input buffer enables
  output logic [7:0] read_data_o // port read value
);

  typedef struct packed {
    logic [7:0] oe;
    logic [7:0] pu;
    logic [7:0] ib;
    logic [7:0] rd;
  } gate_state_t;

  gate_state_t q;
  gate_state_t d;

  // analog pins lose driver, pullup and input path
  always_comb
  begin
    d = q;
    d.oe = out_en_i & ~analog_sel_i;
    d.pu = pullup_en_i & ~analog_sel_i;
    d.ib = ~analog_sel_i;
    d.rd = pad_in_i & ~analog_sel_i;
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      q <= '0;
    else
      q <= d;
  end

  assign out_en_o = q.oe;
  assign pullup_en_o = q.pu;
  assign in_buf_en_o = q.ib;
  assign read_data_o = q.rd;

endmodule : adc_pin_gate

// [src/adc_clock_divider.sv]
/*
  divides the selected source tick by 1, 2, 4 or 8 into a converter clock tick.
  assumes src_tick_i is a one-cycle pulse on ref_clk_i.
*/
`timescale 1ns/10ps
module adc_clock_divider
  import adc_ctrl_pkg::*;
(
  input wire logic ref_clk_i, // bus clock
  input wire logic rstn_i, // async reset, active low
  input wire logic run_i, // converter active
  input wire logic src_tick_i, // selected source tick
  input wire logic [1:0] div_sel_i, // divide select
  output logic tick_o // converter clock tick
);

  typedef struct packed {
    logic [2:0] cnt;
    logic tick;
  } div_state_t;

  div_state_t q;
  div_state_t d;
  logic [2:0] limit;

  // count source ticks up to the ratio minus one
  always_comb
  begin
    limit = 3'((4'h1 << div_sel_i) - 4'h1);
    d = q;
    d.tick = 1'b0;
    if (!run_i)
      d.cnt = 3'h0;
    else if (src_tick_i)
    begin
      if (q.cnt >= limit)
      begin
        d.cnt = 3'h0;
        d.tick = 1'b1;
      end
      else
        d.cnt = 3'(q.cnt + 3'h1);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      q <= '0;
    else
      q <= d;
  end

  assign tick_o = q.tick;

endmodule : adc_clock_divider

// [src/adc_pin_clock_conversion_ctrl.sv]
/*
  converter control: apb registers, pin hand-over, clock source and divide,
  successive approximation sequencing, rounding, compare and done flag.
  assumes the analog core answers cmp_i for the trial code within one cycle,
  and that alt_clk_i is synchronous to ref_clk_i.
*/
`timescale 1ns/10ps
module adc_pin_clock_conversion_ctrl
  import adc_ctrl_pkg::*;
#(
  parameter int ASYNC_DIV = 4 // bus cycles per internal async clock tick
)
(
  input wire logic ref_clk_i, // bus clock, 20 mhz
  input wire logic rstn_i, // async reset, active low
  input wire apb_req_t apb_i, // apb request
  output apb_rsp_t apb_o, // apb response
  input wire port_req_t port_i, // port logic pin requests
  output port_rsp_t port_o, // gated pin controls
  input wire logic alt_clk_i, // alternate clock, sampled
  input wire logic stop_mode_i, // wait or stop, bus and alternate sources halt
  input wire logic cmp_i, // analog comparator: input >= trial
  output logic [11:0] dac_code_o, // trial code to analog core
  output logic [4:0] channel_o, // selected channel
  output logic sample_o, // analog core sampling
  output logic power_o, // analog core powered
  output logic converter_clock_o, // converter clock tick
  output logic irq_o // conversion done interrupt
);

  localparam int ASYNC_W = $clog2(ASYNC_DIV + 1);
  localparam logic [ASYNC_W-1:0] ASYNC_LAST = ASYNC_W'(ASYNC_DIV - 1);

  typedef struct packed {
    conv_state_t state;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [4:0] chan;
    logic irq_en;
    logic done;
    logic irq;
    logic [1:0] clk_sel;
    logic [1:0] mode;
    logic [1:0] div;
    logic cmp_en;
    logic cmp_gt;
    logic [11:0] cmp_val;
    logic [11:0] result;
    logic [11:0] sar;
    logic [3:0] bit_idx;
    logic [4:0] samp_cnt;
    logic [7:0] pins_low;
    logic [7:0] pins_mid;
    logic [7:0] pins_high;
    logic bus_half;
    logic [ASYNC_W-1:0] async_cnt;
    logic async_tick;
    logic alt_prev;
    logic sampling;
    logic power;
  } ctrl_state_t;

  ctrl_state_t q;
  ctrl_state_t d;
  logic conv_tick;
  logic src_tick;
  logic wr_done;
  logic rd_done;
  logic [12:0] round10;
  logic [9:0] round8;
  logic [11:0] value;
  logic [11:0] cmp_mask;
  logic [11:0] diff;
  logic cond;

  ////////////////////////////////////////////////////////////////////////////
  // pin hand-over

  // one gate per pin-select register
  adc_pin_gate u_gate_low (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .analog_sel_i(q.pins_low),
    .out_en_i(port_i.out_en[7:0]),
    .pullup_en_i(port_i.pullup_en[7:0]),
    .pad_in_i(port_i.pad_in[7:0]),
    .out_en_o(port_o.out_en[7:0]),
    .pullup_en_o(port_o.pullup_en[7:0]),
    .in_buf_en_o(port_o.in_buf_en[7:0]),
    .read_data_o(port_o.read_data[7:0])
  );

  adc_pin_gate u_gate_mid (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .analog_sel_i(q.pins_mid),
    .out_en_i(port_i.out_en[15:8]),
    .pullup_en_i(port_i.pullup_en[15:8]),
    .pad_in_i(port_i.pad_in[15:8]),
    .out_en_o(port_o.out_en[15:8]),
    .pullup_en_o(port_o.pullup_en[15:8]),
    .in_buf_en_o(port_o.in_buf_en[15:8]),
    .read_data_o(port_o.read_data[15:8])
  );

  adc_pin_gate u_gate_high (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .analog_sel_i(q.pins_high),
    .out_en_i(port_i.out_en[23:16]),
    .pullup_en_i(port_i.pullup_en[23:16]),
    .pad_in_i(port_i.pad_in[23:16]),
    .out_en_o(port_o.out_en[23:16]),
    .pullup_en_o(port_o.pullup_en[23:16]),
    .in_buf_en_o(port_o.in_buf_en[23:16]),
    .read_data_o(port_o.read_data[23:16])
  );

  ////////////////////////////////////////////////////////////////////////////
  // converter clock

  // source tick: bus and alternate sources halt in stop, the async source does not
  always_comb
  begin
    case (q.clk_sel)
      CLK_BUS: src_tick = !stop_mode_i;
      CLK_BUS_HALF: src_tick = !stop_mode_i && q.bus_half;
      CLK_ALT: src_tick = !stop_mode_i && alt_clk_i && !q.alt_prev;
      default: src_tick = q.async_tick;
    endcase
  end

  adc_clock_divider u_div (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .run_i(d.power), // next power state, so no tick lands in idle
    .src_tick_i(src_tick),
    .div_sel_i(q.div),
    .tick_o(conv_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // result shaping

  // rounding per mode, then compare in that width
  always_comb
  begin
    round10 = 13'({1'b0, q.sar} + 13'h0002);
    round8 = 10'({1'b0, q.sar[11:3]} + 10'h001);
    case (q.mode)
      MODE_10:
      begin
        value = round10[12] ? MAX_10 : {2'h0, round10[11:2]};
        cmp_mask = MAX_10;
      end
      MODE_8:
      begin
        value = round8[9] ? MAX_8 : {4'h0, round8[8:1]};
        cmp_mask = MAX_8;
      end
      default:
      begin
        value = q.sar;
        cmp_mask = 12'hfff;
      end
    endcase
    diff = 12'(value - (q.cmp_val & cmp_mask)) & cmp_mask;
    cond = q.cmp_gt ? (value >= (q.cmp_val & cmp_mask))
                    : (value < (q.cmp_val & cmp_mask));
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers and sequencer

  assign wr_done = apb_i.psel && apb_i.penable && q.pready && apb_i.pwrite;
  assign rd_done = apb_i.psel && apb_i.penable && q.pready && !apb_i.pwrite;

  // next state of the whole block
  always_comb
  begin
    d = q;
    d.pready = 1'b0;
    d.bus_half = !q.bus_half;
    d.alt_prev = alt_clk_i;
    d.async_tick = 1'b0;
    // internal async clock runs only while selected
    if (q.clk_sel == CLK_ASYNC)
    begin
      if (q.async_cnt >= ASYNC_LAST)
      begin
        d.async_cnt = '0;
        d.async_tick = 1'b1;
      end
      else
        d.async_cnt = ASYNC_W'(q.async_cnt + 1'b1);
    end
    else
      d.async_cnt = '0;

    // apb answer one cycle into the access phase
    if (apb_i.psel && apb_i.penable && !q.pready)
    begin
      d.pready = 1'b1;
      d.pslverr = 1'b0;
      d.prdata = 32'h0000_0000;
      if (apb_i.paddr == OFF_CONTROL)
      begin
        d.prdata[CTL_CHAN_LSB +: 5] = q.chan;
        d.prdata[CTL_IRQ_EN_BIT] = q.irq_en;
        d.prdata[CTL_DONE_BIT] = q.done;
      end
      else if (apb_i.paddr == OFF_CONFIG)
      begin
        d.prdata[CFG_CLK_LSB +: 2] = q.clk_sel;
        d.prdata[CFG_MODE_LSB +: 2] = q.mode;
        d.prdata[CFG_DIV_LSB +: 2] = q.div;
      end
      else if (apb_i.paddr == OFF_CMP_CTRL)
      begin
        d.prdata[CMP_GT_BIT] = q.cmp_gt;
        d.prdata[CMP_EN_BIT] = q.cmp_en;
      end
      else if (apb_i.paddr == OFF_CMP_VALUE)
        d.prdata[11:0] = q.cmp_val;
      else if (apb_i.paddr == OFF_RESULT)
        d.prdata[11:0] = q.result;
      else if (apb_i.paddr == OFF_PIN_LOW)
        d.prdata[7:0] = q.pins_low;
      else if (apb_i.paddr == OFF_PIN_MID)
        d.prdata[7:0] = q.pins_mid;
      else if (apb_i.paddr == OFF_PIN_HIGH)
        d.prdata[7:0] = q.pins_high;
      else
        d.pslverr = 1'b1;
    end

    // reading the result or writing control clears the done flag
    if (rd_done && apb_i.paddr == OFF_RESULT)
      d.done = 1'b0;

    // register writes; control starts, config and compare writes abort
    if (wr_done)
    begin
      if (apb_i.paddr == OFF_CONTROL)
      begin
        d.chan = apb_i.pwdata[CTL_CHAN_LSB +: 5];
        d.irq_en = apb_i.pwdata[CTL_IRQ_EN_BIT];
        d.done = 1'b0;
        d.state = ST_SAMPLE;
        d.samp_cnt = 5'h00;
      end
      else if (apb_i.paddr == OFF_CONFIG)
      begin
        d.clk_sel = apb_i.pwdata[CFG_CLK_LSB +: 2];
        d.mode = apb_i.pwdata[CFG_MODE_LSB +: 2];
        d.div = apb_i.pwdata[CFG_DIV_LSB +: 2];
        d.state = ST_IDLE;
      end
      else if (apb_i.paddr == OFF_CMP_CTRL)
      begin
        d.cmp_gt = apb_i.pwdata[CMP_GT_BIT];
        d.cmp_en = apb_i.pwdata[CMP_EN_BIT];
        d.state = ST_IDLE;
      end
      else if (apb_i.paddr == OFF_CMP_VALUE)
      begin
        d.cmp_val = apb_i.pwdata[11:0];
        d.state = ST_IDLE;
      end
      else if (apb_i.paddr == OFF_PIN_LOW)
        d.pins_low = apb_i.pwdata[7:0];
      else if (apb_i.paddr == OFF_PIN_MID)
        d.pins_mid = apb_i.pwdata[7:0];
      else if (apb_i.paddr == OFF_PIN_HIGH)
        d.pins_high = apb_i.pwdata[7:0];
    end
    else
    begin
      // conversion sequencer; sampling and trial steps advance on converter clock ticks
      case (q.state)
        ST_SAMPLE:
        begin
          d.sar = SAR_FIRST;
          d.bit_idx = SAR_MSB;
          if (conv_tick)
          begin
            if (q.samp_cnt >= SAMPLE_TICKS - 5'h01)
              d.state = ST_CONVERT;
            else
              d.samp_cnt = 5'(q.samp_cnt + 5'h01);
          end
        end
        ST_CONVERT:
        begin
          if (conv_tick)
          begin
            if (!cmp_i)
              d.sar[q.bit_idx] = 1'b0;
            if (q.bit_idx == ((q.mode == MODE_8) ? SAR_LSB_9 : SAR_LSB_12))
              d.state = ST_STORE;
            else
            begin
              d.bit_idx = 4'(q.bit_idx - 4'h1);
              d.sar[4'(q.bit_idx - 4'h1)] = 1'b1;
            end
          end
        end
        ST_STORE:
        begin
          d.state = ST_IDLE;
          if (!q.cmp_en)
          begin
            d.result = value;
            d.done = 1'b1;
          end
          else if (cond)
          begin
            d.result = diff;
            d.done = 1'b1;
          end
        end
        default:
          d.state = ST_IDLE;
      endcase
    end

    // all-ones channel disables the converter
    if (d.chan == CHAN_OFF)
      d.state = ST_IDLE;
    d.sampling = (d.state == ST_SAMPLE);
    d.power = (d.state != ST_IDLE);
    d.irq = d.done && d.irq_en;
  end

  // state register; reset leaves converter off and bus clock undivided
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      q <= '0;
      q.state <= ST_IDLE;
      q.chan <= CHAN_OFF;
      q.clk_sel <= CLK_BUS;
      q.div <= 2'h0;
      q.mode <= MODE_8;
      q.cmp_val <= WORD12_ZERO;
      q.result <= WORD12_ZERO;
      q.pins_low <= PINS_RESET;
      q.pins_mid <= PINS_RESET;
      q.pins_high <= PINS_RESET;
    end
    else
      q <= d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign apb_o.prdata = q.prdata;
  assign apb_o.pready = q.pready;
  assign apb_o.pslverr = q.pslverr;
  assign dac_code_o = q.sar;
  assign channel_o = q.chan;
  assign sample_o = q.sampling;
  assign power_o = q.power;
  assign converter_clock_o = conv_tick;
  assign irq_o = q.irq;

endmodule : adc_pin_clock_conversion_ctrl

// [verification/adc_ctrl_chk.sv]
/*
  concurrent checks on the ports of the converter control top.
  assumes ref_clk_i as the only clock and rstn_i as async active-low reset.
*/
`timescale 1ns/10ps
module adc_ctrl_chk
  import adc_ctrl_pkg::*;
#(
  parameter int ASYNC_DIV = 4 // async tick spacing, kept for the bind
)
(
  input wire logic ref_clk_i, // bus clock
  input wire logic rstn_i, // reset, active low
  input wire apb_req_t apb_i, // apb request
  input wire apb_rsp_t apb_o, // apb response
  input wire port_req_t port_i, // port requests
  input wire port_rsp_t port_o, // gated pins
  input wire logic alt_clk_i, // alternate clock
  input wire logic stop_mode_i, // wait or stop
  input wire logic cmp_i, // comparator
  input wire logic [11:0] dac_code_o, // trial code
  input wire logic [4:0] channel_o, // channel
  input wire logic sample_o, // sampling
  input wire logic power_o, // powered
  input wire logic converter_clock_o, // converter tick
  input wire logic irq_o // done interrupt
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  logic acc_end;
  logic ctl_wr;
  // completing access and completing control write
  assign acc_end = apb_i.psel && apb_i.penable && apb_o.pready;
  assign ctl_wr = acc_end && apb_i.pwrite && apb_i.paddr == OFF_CONTROL;
  //////////////////////////////////////////////////////////////////////////////
  // pin gating follows the port request one cycle later
  a_gate_drive: assert property (
    port_o.out_en == ($past(port_i.out_en) & port_o.in_buf_en))
    else $error("output enable of a selected pin not forced off");
  a_gate_pull: assert property (
    port_o.pullup_en == ($past(port_i.pullup_en) & port_o.in_buf_en))
    else $error("pullup of a selected pin not forced off");
  a_gate_read: assert property (
    port_o.read_data == ($past(port_i.pad_in) & port_o.in_buf_en))
    else $error("port read of a selected pin not zero");
  // converter state against channel and completion
  a_chan_off: assert property (
    channel_o == CHAN_OFF && $past(channel_o) == CHAN_OFF |-> !power_o)
    else $error("converter powered with channel off");
  a_idle_quiet: assert property (
    !power_o |-> !sample_o && !converter_clock_o)
    else $error("idle converter sampling or ticking");
  a_done_idle: assert property (
    $rose(irq_o) |-> !power_o)
    else $error("interrupt raised while converter still busy");
  a_irq_clear: assert property (
    ctl_wr |=> !irq_o)
    else $error("interrupt not cleared by control write");
  a_chan_load: assert property (
    ctl_wr |=> channel_o == $past(apb_i.pwdata[4:0]))
    else $error("channel output not loaded by control write");
  // bus answer timing and refusal
  a_one_wait: assert property (
    apb_i.psel && apb_i.penable && !apb_o.pready |=> apb_o.pready ##1 !apb_o.pready)
    else $error("ready not a single pulse after one wait state");
  a_unmapped: assert property (
    acc_end && apb_i.paddr > OFF_PIN_HIGH |-> apb_o.pslverr)
    else $error("unmapped access not refused");
  c_irq: cover property ($rose(irq_o));
  c_chan_off: cover property (ctl_wr && apb_i.pwdata[4:0] == CHAN_OFF);
  c_refused: cover property (acc_end && apb_o.pslverr);
endmodule : adc_ctrl_chk

bind adc_pin_clock_conversion_ctrl adc_ctrl_chk #(.ASYNC_DIV(ASYNC_DIV)) chk (
  .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .apb_i(apb_i), .apb_o(apb_o),
  .port_i(port_i), .port_o(port_o), .alt_clk_i(alt_clk_i), .stop_mode_i(stop_mode_i),
  .cmp_i(cmp_i), .dac_code_o(dac_code_o), .channel_o(channel_o), .sample_o(sample_o),
  .power_o(power_o), .converter_clock_o(converter_clock_o), .irq_o(irq_o)
);

// [verification/analog_core_model.sv]
/*
  behavioural analog core: holds the level seen while sampling and
  compares it with the trial code.
  assumes the level is steady for the whole sampling window.
*/
`timescale 1ns/10ps
module analog_core_model
  import adc_ctrl_pkg::*;
(
  input wire logic ref_clk_i, // bus clock
  input wire logic [11:0] level_i, // analog level as a code
  input wire logic sample_i, // sampling window
  input wire logic power_i, // core powered
  input wire logic [11:0] dac_code_i, // trial code
  output logic cmp_o // 1 = level >= trial
);
  logic [11:0] held_q;
  logic junk_q = 1'b0;
  // track while sampling, then hold; junk toggles so an unpowered answer is useless
  always_ff @(posedge ref_clk_i)
  begin
    if (sample_i)
    begin
      held_q <= level_i;
    end
    junk_q <= ~junk_q;
  end
  // an unpowered core gives no meaningful answer
  assign cmp_o = power_i ? (held_q >= dac_code_i) : junk_q;
endmodule : analog_core_model

// [verification/adc_pin_clock_conversion_ctrl_tb.sv]
/*
  self-checking bench: pin gating rows, conversion rows, then compare,
  abort and refusal cases.
  assumes the hand-over register map and one apb wait state.
*/
`timescale 1ns/10ps
module adc_pin_clock_conversion_ctrl_tb;
  import adc_ctrl_pkg::*;
  localparam int ASYNC_N = 3;
  typedef struct packed {logic [23:0] sel; logic [23:0] drv; logic [23:0] rd;} pin_row_t;
  typedef struct packed {
    logic [1:0] mode; logic [1:0] src; logic [1:0] div; logic [11:0] lvl;
    logic [11:0] res; logic [7:0] gap;
  } conv_row_t;
  typedef struct packed {logic [7:0] ctl; logic [11:0] val; logic dn; logic [11:0] res;} cmp_row_t;
  pin_row_t pins [6] = '{'{24'h0000ff, 24'hffffff, 24'hffff00},
    '{24'h00ff00, 24'hffffff, 24'hff00ff}, '{24'hff0000, 24'hffffff, 24'h00ffff},
    '{24'h5aa581, 24'hf0f0f0, 24'ha05070}, '{24'h000000, 24'h123456, 24'h123456},
    '{24'hffffff, 24'hffffff, 24'h000000}};
  conv_row_t conv [6] = '{'{MODE_12, CLK_BUS, 2'h0, 12'h5a3, 12'h5a3, 8'h01},
    '{MODE_10, CLK_BUS_HALF, 2'h3, 12'h5a3, 12'h169, 8'h10},
    '{MODE_10, CLK_ALT, 2'h2, 12'hfff, 12'h3ff, 8'h10},
    '{MODE_8, CLK_ASYNC, 2'h3, 12'h0a7, 12'h00a, 8'h18},
    '{MODE_8, CLK_BUS, 2'h1, 12'hfff, 12'h0ff, 8'h02},
    '{MODE_12, CLK_BUS, 2'h0, 12'h000, 12'h000, 8'h01}};
  cmp_row_t cmps [3] = '{'{8'h30, 12'h500, 1'b1, 12'h0a3}, '{8'h30, 12'h600, 1'b0, 12'h0a3},
    '{8'h20, 12'h600, 1'b1, 12'hfa3}};
  logic clk, rstn, stop_mode, cmp, sample, power, tick, irq, err;
  logic alt_clk = 1'b0;
  apb_req_t req;
  apb_rsp_t rsp;
  port_req_t pin_req;
  port_rsp_t pin_rsp;
  logic [11:0] dac, level;
  logic [4:0] chan;
  logic [31:0] rd;
  int miscompares, n_checks, gap = 0, last_tick = 0, cyc = 0;
  //////////////////////////////////////////////////////////////////////////////
  adc_pin_clock_conversion_ctrl #(.ASYNC_DIV(ASYNC_N)) uut (
    .ref_clk_i(clk), .rstn_i(rstn), .apb_i(req), .apb_o(rsp), .port_i(pin_req),
    .port_o(pin_rsp), .alt_clk_i(alt_clk), .stop_mode_i(stop_mode), .cmp_i(cmp),
    .dac_code_o(dac), .channel_o(chan), .sample_o(sample), .power_o(power),
    .converter_clock_o(tick), .irq_o(irq));
  analog_core_model core (.ref_clk_i(clk), .level_i(level), .sample_i(sample),
    .power_i(power), .dac_code_i(dac), .cmp_o(cmp));
  // clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // cycle count, alternate clock of four cycles, converter tick spacing
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    alt_clk <= (cyc % 4) >= 2;
    if (tick)
    begin
      gap <= cyc - last_tick;
      last_tick <= cyc;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one apb transfer, held until ready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 20);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (n == 20) miscompares++;
  endtask : apb
  // wait for the converter to fall idle
  task automatic wait_idle();
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (power !== 1'b0 && n < 2000);
    if (n == 2000) miscompares++;
  endtask : wait_idle
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
    begin
      $display("Simulation passed");
    end
    else
    begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  // watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    stop_test();
  end
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rstn, stop_mode, miscompares, n_checks} = '0;
    req = '0;
    pin_req = '0;
    level = 12'h000;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, OFF_CONTROL, 32'h0);
    check("control reset", rd, 32'h1f);
    apb(1'b0, OFF_CONFIG, 32'h0);
    check("config reset", rd, 32'h0);
    $display("test reset done");
    // pin rows
    foreach (pins[i])
    begin
      pin_req <= '{pins[i].drv, ~pins[i].drv, pins[i].drv};
      for (int b = 0; b < 3; b++)
      begin
        if (i == 0) apb(1'b0, OFF_PIN_LOW + 8'(4 * b), 32'h0);
        if (i == 0) check("pin reset", rd, 32'h0);
        apb(1'b1, OFF_PIN_LOW + 8'(4 * b), 32'(pins[i].sel[8*b +: 8]));
        apb(1'b0, OFF_PIN_LOW + 8'(4 * b), 32'h0);
        check("pin select", rd, 32'(pins[i].sel[8*b +: 8]));
      end
      @(posedge clk);
      check("read", 32'(pin_rsp.read_data), 32'(pins[i].rd));
      check("out_en", 32'(pin_rsp.out_en), 32'(pins[i].drv & ~pins[i].sel));
      check("pullup", 32'(pin_rsp.pullup_en), {8'h0, ~pins[i].drv & ~pins[i].sel});
      check("in_buf", 32'(pin_rsp.in_buf_en), {8'h0, ~pins[i].sel});
      $display("test pins %0d done", i);
    end
    // conversion rows: every source, divide and mode
    foreach (conv[i])
    begin
      level <= conv[i].lvl;
      stop_mode <= (conv[i].src == CLK_ASYNC);
      apb(1'b1, OFF_CONFIG, {25'h0, conv[i].div, 1'b0, conv[i].mode, conv[i].src});
      apb(1'b1, OFF_CONTROL, {24'h0, 1'b0, ~i[0], 1'b0, 5'h03});
      wait_idle();
      repeat (2) @(posedge clk);
      check("irq", 32'(irq), {31'h0, ~i[0]});
      check("tick gap", 32'(gap), 32'(conv[i].gap));
      apb(1'b0, OFF_CONTROL, 32'h0);
      check("done", 32'(rd[7]), 32'h1);
      apb(1'b0, OFF_RESULT, 32'h0);
      check("result", rd, 32'(conv[i].res));
      $display("test conversion %0d done", i);
    end
    stop_mode <= 1'b0;
    // compare gate: greater-or-equal met, not met, then less-than met
    level <= 12'h5a3;
    apb(1'b1, OFF_CONFIG, 32'h04);
    foreach (cmps[i])
    begin
      apb(1'b1, OFF_CMP_VALUE, 32'(cmps[i].val));
      apb(1'b1, OFF_CMP_CTRL, 32'(cmps[i].ctl));
      apb(1'b1, OFF_CONTROL, 32'h03);
      wait_idle();
      apb(1'b0, OFF_CONTROL, 32'h0);
      check("compare done", 32'(rd[7]), 32'(cmps[i].dn));
      apb(1'b0, OFF_RESULT, 32'h0);
      check("compare result", rd, 32'(cmps[i].res));
    end
    apb(1'b1, OFF_CMP_CTRL, 32'h0);
    $display("test compare done");
    // finish one with irq on, then a control write must drop it
    apb(1'b1, OFF_CONTROL, 32'h43);
    wait_idle();
    check("irq set", 32'(irq), 32'h1);
    // abort by channel all ones while still sampling
    apb(1'b1, OFF_CONFIG, 32'h63);
    apb(1'b1, OFF_CONTROL, 32'h03);
    repeat (10) @(posedge clk);
    check("busy", 32'(power), 32'h1);
    check("irq cleared", 32'(irq), 32'h0);
    apb(1'b1, OFF_CONTROL, 32'h1f);
    repeat (2) @(posedge clk);
    check("off", 32'(power), 32'h0);
    check("channel", 32'(chan), 32'h1f);
    $display("test abort done");
    // unmapped address refused
    apb(1'b1, 8'h20, 32'hff);
    check("refused write", 32'(err), 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    check("refused read", {rd[30:0], err}, 32'h1);
    $display("test refusal done");
    // mid-run reset hands every pin back and restores the bus clock
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, OFF_PIN_HIGH, 32'h0);
    check("pin after reset", rd, 32'h0);
    check("in_buf after reset", 32'(pin_rsp.in_buf_en), 32'hffffff);
    apb(1'b0, OFF_CONFIG, 32'h0);
    check("config after reset", rd, 32'h0);
    $display("test mid-run reset done");
    stop_test();
  end
endmodule : adc_pin_clock_conversion_ctrl_tb
